// >>> hw/tdcm_pkg.sv
package tdcm_pkg;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0]  ADDR_CFG    = 8'h00;
  localparam logic [7:0]  ADDR_CTRL   = 8'h04;
  localparam logic [7:0]  ADDR_STATUS = 8'h08;
  localparam logic [7:0]  ADDR_RES    = 8'h0C;
  localparam logic [7:0]  ADDR_SUM    = 8'h10;
  localparam logic [31:0] CFG_RST     = 32'h0008_2600;
  // ----------------------------------------
  // cfg field positions
  // ----------------------------------------
  localparam int F_MODE2   = 0;
  localparam int F_ST_FALL = 1;
  localparam int F_C1_FALL = 2;
  localparam int F_C1_BOTH = 3;
  localparam int F_C2_FALL = 4;
  localparam int F_C2_BOTH = 5;
  localparam int F_ANALOG  = 6;
  localparam int F_AUTOSUM = 7;
  localparam int F_ERRFILL = 8;
  localparam int F_CHARGE  = 9;
  localparam int F_TIMO    = 11;
  localparam int F_EXP1    = 13;
  localparam int F_EXP2    = 16;
  localparam int F_OP1     = 19;
  localparam int F_OP2     = 23;
  localparam int F_IRQEN   = 27;
  // status flag bits
  localparam int S_TIMO = 0;
  localparam int S_ENDH = 1;
  localparam int S_ALU  = 2;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS     = 5;
  localparam int US_NS      = 1000;
  localparam int CYC_PER_US = US_NS / CLK_NS;
  localparam int MODE2_HITS = 3;
  localparam logic [10:0] TIMO_US0 = 11'd64;
  localparam logic [10:0] TIMO_US1 = 11'd256;
  localparam logic [10:0] TIMO_US2 = 11'd512;
  localparam logic [10:0] TIMO_US3 = 11'd1024;
  localparam logic [10:0] CHG_US0  = 11'd90;
  localparam logic [10:0] CHG_US1  = 11'd120;
  localparam logic [10:0] CHG_US2  = 11'd150;
  localparam logic [10:0] CHG_US3  = 11'd300;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CAP  = 4'b0010,
    ST_CALC = 4'b0100,
    ST_DONE = 4'b1000
  } tdcm_state_t;
endpackage

// >>> hw/tdcm_chan.sv
module tdcm_chan #(
  parameter int HITS = 4
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst_b,
  input  wire logic               i_pin,
  input  wire logic               i_fall,
  input  wire logic               i_both,
  input  wire logic               i_arm,
  input  wire logic               i_run,
  input  wire logic [2:0]         i_limit,
  input  wire logic [31:0]        i_ts,
  output logic      [2:0]         o_cnt,
  output logic                    o_full,
  output logic      [HITS*32-1:0] o_times
);
  if (HITS < 1 || HITS > 7) begin : g_chk
    $error("tdcm_chan: HITS out of range");
  end
  logic        prev_r;
  logic [2:0]  cnt_r;
  logic [31:0] t_r [HITS];
  wire rise = i_pin & ~prev_r;
  wire fall = ~i_pin & prev_r;
  wire hit  = i_both ? (rise | fall) : (i_fall ? fall : rise);
  wire full = (cnt_r >= i_limit);
  wire take = i_run & hit & ~full;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_r <= 1'b0;
      cnt_r  <= 3'h0;
    end else begin
      prev_r <= i_pin;
      if (i_arm) begin
        cnt_r <= 3'h0;
      end else if (take) begin
        cnt_r <= cnt_r + 3'h1;
      end
    end
  end

  for (genvar g = 0; g < HITS; g++) begin : g_hit
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        t_r[g] <= 32'h0000_0000;
      end else if (take && cnt_r == 3'(g)) begin
        t_r[g] <= i_ts;
      end
    end
    assign o_times[g*32 +: 32] = t_r[g];
  end
  assign o_cnt  = cnt_r;
  assign o_full = full;
endmodule

// >>> hw/tdcm_us_timer.sv
module tdcm_us_timer #(
  parameter int CYC_PER_US = 200
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_start,
  input  wire logic        i_stop,
  input  wire logic [10:0] i_lim_us,
  output logic             o_busy,
  output logic             o_expire
);
  if (CYC_PER_US < 2 || CYC_PER_US > 1023) begin : g_chk
    $error("tdcm_us_timer: CYC_PER_US out of range");
  end
  logic [9:0]  div_r;
  logic [10:0] us_r;
  logic        busy_r;
  // one-cycle microsecond enable from the divider
  wire tick = busy_r && div_r == 10'(CYC_PER_US - 1);
  wire done = tick && (us_r + 11'h1) >= i_lim_us;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_r  <= 10'h000;
      us_r   <= 11'h000;
      busy_r <= 1'b0;
    end else if (i_start) begin
      div_r  <= 10'h000;
      us_r   <= 11'h000;
      busy_r <= 1'b1;
    end else if (i_stop || done) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      div_r <= tick ? 10'h000 : div_r + 10'h001;
      us_r  <= tick ? us_r + 11'h001 : us_r;
    end
  end
  assign o_busy   = busy_r;
  assign o_expire = done & ~i_start & ~i_stop;
endmodule

// >>> hw/tdcm_top.sv
// Notes on behaviour
// - mode 2 result is second operand time minus first operand time
// - mode 2 captures at most three hits on stop channel one
// - mode 2 second operand picks hit one, two or three of channel one
// - mode 2 first operand is always the start event
// - mode 1 result is first operand time minus second operand time
// - mode 1 operands pick start or any of the first four hits on either stop channel
// - mode bit set selects mode 2, cleared selects mode 1
// - analog select off: digital stop pins; on: analog receiver feeds stop one, stop two stays digital
// - charge time selectable 90, 120, 150, 300 us, default 300
// - mode 2 auto hit sum computes three hit results and their sum register
// - timeout 64 to 1024 us flags missing hits
// - separate expected hit counts for stop channels one and two
// - start edge: falling when bit set, else rising
// - stop one edge: falling or rising, or both edges
// - stop two edge: falling or rising, or both edges
// - interrupt on timeout, end of hits, calculation done, each enabled
// - timeout error fill writes all ones into the result
module tdcm_top
  import tdcm_pkg::*;
#(
  parameter int HITS = 4
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_start,
  input  wire logic        i_stop_channel_one,
  input  wire logic        i_stop_channel_two,
  input  wire logic        i_analog_stop,
  output logic             o_charge_capacitor,
  output logic             o_busy,
  output logic             o_irq
);
  import tdcm_pkg::*;
  if (HITS != 4) begin : g_chk
    $error("tdcm_top: operand encoding serves four hits per channel");
  end
  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  logic [31:0] cfg_r;
  logic [31:0] prdata_r;
  logic [31:0] res_r;
  logic [31:0] sum_r;
  logic [2:0]  flag_r;
  logic [31:0] ts_r;
  tdcm_state_t st_r;
  tdcm_state_t st_nxt;

  wire acc      = i_psel & i_penable;
  wire setup_rd = i_psel & ~i_penable & ~i_pwrite;
  wire wr       = acc & i_pwrite;
  wire hit_cfg  = i_paddr == ADDR_CFG;
  wire hit_ctrl = i_paddr == ADDR_CTRL;
  wire hit_stat = i_paddr == ADDR_STATUS;
  wire hit_res  = i_paddr == ADDR_RES;
  wire hit_sum  = i_paddr == ADDR_SUM;
  wire mapped   = hit_cfg | hit_ctrl | hit_stat | hit_res | hit_sum;
  wire cfg_wr   = wr & hit_cfg;
  wire arm      = wr & hit_ctrl & i_pwdata[0];
  wire [2:0] clr = (wr & hit_stat) ? i_pwdata[2:0] : 3'h0;

  // ----------------------------------------
  // configuration fields
  // ----------------------------------------
  wire       mode2   = cfg_r[F_MODE2];
  wire       analog  = cfg_r[F_ANALOG];
  wire       autosum = cfg_r[F_AUTOSUM];
  wire       errfill = cfg_r[F_ERRFILL];
  wire [1:0] chg_sel = cfg_r[F_CHARGE +: 2];
  wire [1:0] tmo_sel = cfg_r[F_TIMO +: 2];
  wire [2:0] exp1    = cfg_r[F_EXP1 +: 3];
  wire [2:0] exp2    = cfg_r[F_EXP2 +: 3];
  wire [3:0] op1_sel = cfg_r[F_OP1 +: 4];
  wire [3:0] op2_sel = cfg_r[F_OP2 +: 4];
  wire [2:0] irq_en  = cfg_r[F_IRQEN +: 3];
  // mode 2 caps channel one at three hits
  wire [2:0] lim1 = (mode2 && exp1 > 3'(MODE2_HITS)) ? 3'(MODE2_HITS) : exp1;
  // stop one path follows the front-end select
  wire stop_channel_one_src = analog ? i_analog_stop : i_stop_channel_one;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_r <= CFG_RST;
    end else if (cfg_wr) begin
      cfg_r <= i_pwdata;
    end
  end

  // ----------------------------------------
  // capture channels
  // ----------------------------------------
  wire cap = st_r == ST_CAP;
  logic [2:0]         st_cnt;
  logic [2:0]         c1_cnt;
  logic [2:0]         c2_cnt;
  logic               st_full;
  logic               c1_full;
  logic               c2_full;
  logic [31:0]        st_t;
  logic [HITS*32-1:0] c1_t;
  logic [HITS*32-1:0] c2_t;
  // stops before the start event carry no meaning, so they are held off
  wire stop_run = cap & st_full;

  tdcm_chan #(.HITS(1)) u_start (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_pin   (i_start),
    .i_fall  (cfg_r[F_ST_FALL]),
    .i_both  (1'b0),
    .i_arm   (arm),
    .i_run   (cap),
    .i_limit (3'h1),
    .i_ts    (ts_r),
    .o_cnt   (st_cnt),
    .o_full  (st_full),
    .o_times (st_t)
  );
  tdcm_chan #(.HITS(HITS)) u_stop_channel_one (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_pin   (stop_channel_one_src),
    .i_fall  (cfg_r[F_C1_FALL]),
    .i_both  (cfg_r[F_C1_BOTH]),
    .i_arm   (arm),
    .i_run   (stop_run),
    .i_limit (lim1),
    .i_ts    (ts_r),
    .o_cnt   (c1_cnt),
    .o_full  (c1_full),
    .o_times (c1_t)
  );
  tdcm_chan #(.HITS(HITS)) u_stop_channel_two (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_pin   (i_stop_channel_two),
    .i_fall  (cfg_r[F_C2_FALL]),
    .i_both  (cfg_r[F_C2_BOTH]),
    .i_arm   (arm),
    .i_run   (stop_run & ~mode2),
    .i_limit (mode2 ? 3'h0 : exp2),
    .i_ts    (ts_r),
    .o_cnt   (c2_cnt),
    .o_full  (c2_full),
    .o_times (c2_t)
  );

  // ----------------------------------------
  // timers
  // ----------------------------------------
  wire [10:0] tmo_us = tmo_sel == 2'h0 ? TIMO_US0 : tmo_sel == 2'h1 ? TIMO_US1 :
                       tmo_sel == 2'h2 ? TIMO_US2 : TIMO_US3;
  wire [10:0] chg_us = chg_sel == 2'h0 ? CHG_US0 : chg_sel == 2'h1 ? CHG_US1 :
                       chg_sel == 2'h2 ? CHG_US2 : CHG_US3;
  wire all_hits = st_full & c1_full & c2_full;
  logic timo_exp;
  logic chg_busy;

  tdcm_us_timer #(.CYC_PER_US(CYC_PER_US)) u_timo (
    .i_clk    (i_clk),
    .i_rst_b  (i_rst_b),
    .i_start  (arm),
    .i_stop   (cap & all_hits),
    .i_lim_us (tmo_us),
    .o_busy   (),
    .o_expire (timo_exp)
  );
  tdcm_us_timer #(.CYC_PER_US(CYC_PER_US)) u_chg (
    .i_clk    (i_clk),
    .i_rst_b  (i_rst_b),
    .i_start  (arm & analog),
    .i_stop   (~analog),
    .i_lim_us (chg_us),
    .o_busy   (chg_busy),
    .o_expire ()
  );
  assign o_charge_capacitor = chg_busy;

  // ----------------------------------------
  // operand selection and arithmetic
  // ----------------------------------------
  // code 0 is start, 1..4 channel one hits, 5..8 channel two hits
  function automatic logic [31:0] pick(input logic [3:0] s);
    logic [31:0] v;
    v = st_t;
    if (s >= 4'h1 && s <= 4'h4) begin
      v = c1_t[(s - 4'h1)*32 +: 32];
    end else if (s >= 4'h5 && s <= 4'h8) begin
      v = c2_t[(s - 4'h5)*32 +: 32];
    end
    return v;
  endfunction

  // mode 2 only offers channel one hits one to three; others fall back to hit one
  wire [3:0]  op2_m2 = (op2_sel >= 4'h1 && op2_sel <= 4'h3) ? op2_sel : 4'h1;
  wire [31:0] op1_t  = mode2 ? st_t : pick(op1_sel);
  wire [31:0] op2_t  = mode2 ? pick(op2_m2) : pick(op2_sel);
  wire [31:0] diff_t = mode2 ? op2_t - op1_t : op1_t - op2_t;
  wire [31:0] sum_t  = (c1_t[31:0] - st_t) + (c1_t[63:32] - st_t) + (c1_t[95:64] - st_t);
  wire        fail   = cap & ~all_hits & timo_exp;
  wire        to_calc = cap & all_hits;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: st_nxt = ST_IDLE;
      ST_CAP:  st_nxt = to_calc ? ST_CALC : (fail ? ST_DONE : ST_CAP);
      ST_CALC: st_nxt = ST_DONE;
      ST_DONE: st_nxt = ST_DONE;
      default: st_nxt = ST_IDLE;
    endcase
    if (arm) begin
      st_nxt = ST_CAP;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r  <= ST_IDLE;
      ts_r  <= 32'h0000_0000;
      res_r <= 32'h0000_0000;
      sum_r <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
      ts_r <= ts_r + 32'h0000_0001;
      if (st_r == ST_CALC) begin
        res_r <= diff_t;
        sum_r <= (mode2 && autosum) ? sum_t : 32'h0000_0000;
      end else if (fail && errfill) begin
        res_r <= 32'hFFFF_FFFF;
        sum_r <= 32'hFFFF_FFFF;
      end
    end
  end

  // ----------------------------------------
  // status flags and interrupt
  // ----------------------------------------
  // a new event wins over a clear in the same cycle
  wire [2:0] set = {st_r == ST_CALC, to_calc, fail};
  wire [2:0] flag_nxt = (flag_r & ~clr) | set;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flag_r   <= 3'h0;
      prdata_r <= 32'h0000_0000;
    end else begin
      flag_r <= flag_nxt;
      if (setup_rd) begin
        prdata_r <= hit_cfg  ? cfg_r :
                    hit_stat ? {22'h00_0000, c2_cnt, c1_cnt, cap, flag_r} :
                    hit_res  ? res_r :
                    hit_sum  ? sum_r : 32'h0000_0000;
      end
    end
  end

  assign o_irq     = |(flag_r & irq_en);
  assign o_busy    = cap;
  assign o_prdata  = prdata_r;
  assign o_pready  = 1'b1;
  assign o_pslverr = acc & ~mapped;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  arm_clear_a: assert property (arm |=> c1_cnt == 3'h0 && c2_cnt == 3'h0)
    else $error("arm did not clear hit counts");
  hit_freeze_a: assert property (c1_full && !arm && !cfg_wr |=> c1_cnt == $past(c1_cnt))
    else $error("full channel still counted");
  mode2_cap_a: assert property (mode2 && !cfg_wr && c1_cnt <= 3'h3 |=> c1_cnt <= 3'h3)
    else $error("more than three hits in mode 2");
  mode2_res_a: assert property (st_r == ST_CALC && mode2 |=> res_r + $past(st_t) == $past(op2_t))
    else $error("mode 2 result wrong");
  mode1_res_a: assert property (st_r == ST_CALC && !mode2 |=> res_r == $past(op1_t) - $past(op2_t))
    else $error("mode 1 result wrong");
  auto_sum_a: assert property (st_r == ST_CALC && mode2 && autosum |=> sum_r == $past(sum_t))
    else $error("hit sum wrong");
  timo_fill_a: assert property (fail && errfill && !arm |=> res_r == 32'hFFFF_FFFF && st_r == ST_DONE)
    else $error("timeout fill missing");
  timo_flag_a: assert property (fail |=> flag_r[S_TIMO] ##1 flag_r[S_TIMO] || $past(clr[S_TIMO]))
    else $error("timeout flag not set");
  end_irq_a: assert property (to_calc && irq_en[S_ENDH] && !cfg_wr |=> o_irq)
    else $error("end of hits interrupt missing");

  timo_c: cover property (cap ##1 fail);
  mode2_calc_c: cover property (mode2 && to_calc ##1 st_r == ST_CALC);
  sum_c: cover property (st_r == ST_CALC && autosum && mode2);
endmodule

// >>> tb/tdcm_pulse_src.sv
module tdcm_pulse_src #(
  parameter int GAP = 8,
  parameter int WID = 3
) (
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [2:0] i_n1,
  input  wire logic [2:0] i_n2,
  input  wire logic       i_ana,
  output logic            o_start,
  output logic            o_stop_one,
  output logic            o_stop_two,
  output logic            o_analog
);
  timeunit 1ns;
  timeprecision 100ps;
  int   t = 99;
  logic s1;
  // ----------------------------------------
  // pulse train: start at 2, hit k at 2+k*gap on stop one, 3+k*gap on stop two
  // ----------------------------------------
  function automatic logic pl(input int tt, input int n, input int off);
    pl = 1'b0;
    for (int k = 1; k <= n; k++) begin
      if (tt >= 2 + GAP * k + off && tt < 2 + GAP * k + off + WID) pl = 1'b1;
    end
  endfunction
  always @(posedge i_clk) begin
    if (i_go) t <= 0;
    else if (t < 99) t <= t + 1;
  end
  assign o_start    = (t >= 2) && (t < 2 + WID);
  assign s1         = pl(t, int'(i_n1), 0);
  // the unused receive path toggles within a frame, so a wrong path cannot pass
  assign o_stop_one = i_ana ? t[0] : s1;
  assign o_analog   = i_ana ? s1 : t[0];
  assign o_stop_two = pl(t, int'(i_n2), 1);
endmodule

// >>> tb/tb.sv
module tb;
  import tdcm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int G = 8;
  localparam int W = 3;
  logic        i_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic        go = 1'b0;
  logic        ana_sel = 1'b0;
  logic [2:0]  n1 = 3'd0;
  logic [2:0]  n2 = 3'd0;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic        start;
  logic        stop_channel_one;
  logic        stop_channel_two;
  logic        ana;
  logic        o_charge_capacitor;
  logic        o_busy;
  logic        o_irq;
  logic [31:0] rdata;
  logic [31:0] st;
  logic        perr;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          arm_cyc = 0;
  int          chg_cyc = 0;

  tdcm_top #(.HITS(4)) dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_start(start),
    .i_stop_channel_one(stop_channel_one), .i_stop_channel_two(stop_channel_two), .i_analog_stop(ana),
    .o_charge_capacitor(o_charge_capacitor), .o_busy(o_busy), .o_irq(o_irq));
  tdcm_pulse_src #(.GAP(G), .WID(W)) src (
    .i_clk(i_clk), .i_go(go), .i_n1(n1), .i_n2(n2), .i_ana(ana_sel),
    .o_start(start), .o_stop_one(stop_channel_one), .o_stop_two(stop_channel_two), .o_analog(ana));

  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_charge_capacitor === 1'b1) chg_cyc <= chg_cyc + 1;
  end
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    i_penable <= 1'b0;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rdata = o_prdata;
    perr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] cf(input int md, e1, e2, o1, o2, input logic [31:0] ex);
    cf = ex | (32'(md) << F_MODE2) | (32'(e1) << F_EXP1) | (32'(e2) << F_EXP2)
            | (32'(o1) << F_OP1) | (32'(o2) << F_OP2);
  endfunction
  // arms, fires one pulse train, polls until calc or timeout, then reads the result
  task meas(input logic [31:0] c, input int a, input int b);
    apb(1'b1, ADDR_CFG, c);
    apb(1'b1, ADDR_STATUS, 32'h0000_0007);
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    arm_cyc = cyc;
    n1 <= 3'(a);
    n2 <= 3'(b);
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    // one poll is three cycles: the limit must outlast the 64 us timeout
    for (int i = 0; i < 5000; i++) begin
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      st = rdata;
      if (st[S_ALU] === 1'b1 || st[S_TIMO] === 1'b1) break;
    end
    chk("measure end", 32'h0000_0001, 32'(st[S_ALU] | st[S_TIMO]));
    apb(1'b0, ADDR_RES, 32'h0000_0000);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task s_reset;
    apb(1'b0, ADDR_CFG, 32'h0000_0000);
    chk("cfg reset", CFG_RST, rdata);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, 32'(perr));
    chk("unmapped data", 32'h0000_0000, rdata);
  endtask
  task s_mode1;
    int o1[4] = '{2, 1, 0, 6};
    int o2[4] = '{5, 0, 1, 2};
    int ex[4] = '{G - 1, G, -G, 1};
    for (int i = 0; i < 4; i++) begin
      meas(cf(0, 2, 2, o1[i], o2[i], 0), 2, 2);
      chk("mode1 result", 32'(ex[i]), rdata);
    end
  endtask
  task s_mode2;
    // channel two expects hits but is never pulsed: mode 2 must not wait for it
    for (int k = 1; k <= 3; k++) begin
      meas(cf(1, 3, 2, 6, k, 0), 3, 0);
      chk("mode2 result", 32'(G * k), rdata);
    end
    meas(cf(1, 3, 0, 6, 1, 32'(1) << F_AUTOSUM), 3, 0);
    apb(1'b0, ADDR_SUM, 32'h0000_0000);
    chk("hit sum", 32'(6 * G), rdata);
    meas(cf(1, 4, 0, 0, 1, 0), 4, 0);
    // the fourth pulse lands after the result, so look again once it has passed
    repeat (30) @(posedge i_clk);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk("mode2 cap", 32'h0000_0003, 32'(rdata[6:4]));
  endtask
  task s_edges;
    int f[5]  = '{F_ST_FALL, F_C1_FALL, F_C1_BOTH, F_C2_FALL, F_C2_BOTH};
    int a1[5] = '{1, 1, 2, 5, 6};
    int a2[5] = '{0, 0, 1, 0, 5};
    int e1[5] = '{1, 1, 2, 0, 0};
    int e2[5] = '{0, 0, 0, 1, 2};
    int ex[5] = '{G - W, G + W, W, G + 1 + W, W};
    for (int i = 0; i < 5; i++) begin
      meas(cf(0, e1[i], e2[i], a1[i], a2[i], 32'(1) << f[i]), e1[i] > 0, e2[i] > 0);
      chk("edge result", 32'(ex[i]), rdata);
    end
  endtask
  task s_limit;
    meas(cf(0, 2, 0, 2, 1, 0), 3, 0);
    chk("limit result", 32'(G), rdata);
    repeat (30) @(posedge i_clk);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk("count full", 32'h0000_0002, 32'(rdata[6:4]));
    chk("busy done", 32'h0000_0000, 32'(o_busy));
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk("count rearm", 32'h0000_0000, 32'(rdata[6:4]));
    chk("busy rearm", 32'h0000_0001, 32'(o_busy));
  endtask
  task s_irq;
    meas(cf(0, 1, 0, 1, 0, 32'(1) << F_IRQEN), 1, 0);
    chk("irq masked", 32'h0000_0000, 32'(o_irq));
    meas(cf(0, 1, 0, 1, 0, 32'(4) << F_IRQEN), 1, 0);
    chk("irq alu", 32'h0000_0001, 32'(o_irq));
    meas(cf(0, 1, 0, 1, 0, 32'(2) << F_IRQEN), 1, 0);
    chk("irq end hits", 32'h0000_0001, 32'(o_irq));
  endtask
  task s_timeout;
    int span;
    meas(cf(0, 4, 0, 1, 0, (32'(1) << F_ERRFILL) | (32'(1) << F_IRQEN)), 1, 0);
    span = cyc - arm_cyc;
    chk("err fill", 32'hFFFF_FFFF, rdata);
    chk("timeout flag", 32'h0000_0001, 32'(st[S_TIMO]));
    chk("timeout span", 32'h0000_0001, 32'(span >= 64 * CYC_PER_US && span < 64 * CYC_PER_US + 40));
    chk("irq timeout", 32'h0000_0001, 32'(o_irq));
    apb(1'b1, ADDR_STATUS, 32'h0000_0007);
    repeat (2) @(posedge i_clk);
    chk("irq clear", 32'h0000_0000, 32'(o_irq));
  endtask
  task s_analog;
    int c0;
    ana_sel <= 1'b1;
    c0 = chg_cyc;
    meas(cf(0, 1, 0, 1, 0, 32'(1) << F_ANALOG), 1, 0);
    chk("analog result", 32'(G), rdata);
    for (int i = 0; i < 20000 && o_charge_capacitor !== 1'b0; i++) @(posedge i_clk);
    c0 = chg_cyc - c0;
    chk("charge span", 32'h0000_0001, 32'(c0 >= 90 * CYC_PER_US - 2 && c0 <= 90 * CYC_PER_US + 2));
    ana_sel <= 1'b0;
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    s_reset;
    s_mode1;
    s_mode2;
    s_edges;
    s_limit;
    s_irq;
    s_timeout;
    s_analog;
    conclude;
  end
  // whole run is about 32000 cycles; the limit leaves ample margin
  initial begin
    repeat (60000) @(posedge i_clk);
    fail_count++;
    conclude;
  end
endmodule
